// >>> tb/scgd_cpu_model.sv
// processor model: acknowledges a suspend request after LAT+1 clocks
// assumes the bench raises the request and the readiness level
`timescale 1ns/1ns
module scgd_cpu_model #(
  parameter int LAT = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_suspend_req,
  input wire logic i_ready,
  output logic o_suspend_acknowledge_n = 1'b1,
  output logic o_ack_based_gating
);
  int cnt = 0;
  // pin released on the first clock edge after the request drops
  always @(posedge i_clk_sys) begin
    cnt <= i_suspend_req ? cnt + 1 : 0;
    o_suspend_acknowledge_n <= !(i_suspend_req && cnt >= LAT);
  end
  // readiness only means something while acknowledged
  assign o_ack_based_gating = i_ready && !o_suspend_acknowledge_n;
endmodule // scgd_cpu_model

// >>> tb/scgd_props.sv
// checker: port relations of the sleep gating controller
// assumes it is bound onto scgd_gate_ctrl
`timescale 1ns/1ns
module scgd_props
  import scgd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire scgd_req_t i_msr_req,
  input wire logic i_suspend_acknowledge_n,
  input wire logic i_ack_based_gating,
  input wire scgd_rsp_t o_msr_rsp,
  input wire logic [SCGD_MASK_W-1:0] o_clock_force_off,
  input wire logic o_gating_active,
  input wire logic o_delay_gating_enable
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // short names for the watched signals
  wire ga = o_gating_active;
  wire en = o_delay_gating_enable;
  wire rd = i_msr_req.rd;
  wire [31:0] a = i_msr_req.addr;
  // six clocks cover the pin synchroniser and edge detect
  sequence s_rdy;
    (!i_suspend_acknowledge_n && i_ack_based_gating && !en)[*6];
  endsequence
  sequence s_rel;
    i_suspend_acknowledge_n[*6];
  endsequence
  property p_idle; !ga |-> o_clock_force_off == '0; endproperty
  property p_rsv; rd && a == SCGD_A_DELAY |=> o_msr_rsp.rdata[63:24] == '0;
  endproperty
  property p_en; i_msr_req.wr && a == SCGD_A_GLB |=>
    en == $past(i_msr_req.wdata[1]); endproperty
  property p_ack; $rose(ga) |-> $past(i_suspend_acknowledge_n, 3) == 1'b0;
  endproperty
  property p_rel; s_rel |-> !ga; endproperty
  property p_mode; s_rdy |=> ga; endproperty
  property p_vld; rd |=> o_msr_rsp.valid; endproperty
  property p_nov; !rd |=> !o_msr_rsp.valid; endproperty
  a_idle: assert property (p_idle) else $error("clocks off idle");
  a_rsv: assert property (p_rsv) else $error("delay upper bits");
  a_en: assert property (p_en) else $error("enable not stored");
  a_ack: assert property (p_ack) else $error("gated without ack");
  a_rel: assert property (p_rel) else $error("gating kept");
  a_mode: assert property (p_mode) else $error("ack gating late");
  a_vld: assert property (p_vld) else $error("no read answer");
  a_nov: assert property (p_nov) else $error("stray answer");
endmodule // scgd_props

// >>> tb/sleep_clock_gating_delay_tb.sv
// bench: register access and sleep gating sequences
// assumes the processor model drives the acknowledge pin
`timescale 1ns/1ns
module sleep_clock_gating_delay_tb;
  import scgd_pkg::*;
  logic i_clk_sys = 0, i_rst_n = 0, sreq = 0, rdy = 0;
  logic i_suspend_acknowledge_n, i_ack_based_gating, o_gating_active;
  logic o_delay_gating_enable;
  logic [SCGD_MASK_W-1:0] o_clock_force_off;
  scgd_req_t i_msr_req = '0;
  scgd_rsp_t o_msr_rsp;
  int n_errors = 0, n_checks = 0, cyc = 0, n;
  localparam logic [63:0] MSK = 64'hffff_2345_6789_abcd;
  scgd_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_suspend_req(sreq),
    .i_ready(rdy), .o_suspend_acknowledge_n(i_suspend_acknowledge_n),
    .o_ack_based_gating(i_ack_based_gating));
  scgd_gate_ctrl dut (.*);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // hang guard, well above the run of about 600 clocks
  always @(posedge i_clk_sys) if (++cyc > 5000) begin
    n_errors++;
    test_done;
  end
  task automatic chk(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access; a read compares against d
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge i_clk_sys) #1 i_msr_req = '{a, w, !w, d};
    @(posedge i_clk_sys) #1 i_msr_req = '0;
    if (!w) chk(o_msr_rsp.rdata, d);
  endtask
  // reset values, reserved bits, scratch and an unmapped place
  task automatic t_regs;
    acc(0, SCGD_A_GLB, 0);
    acc(0, SCGD_A_MASK, 0);
    acc(1, SCGD_A_DELAY, '1);
    acc(0, SCGD_A_DELAY, 64'hff_ffff);
    acc(1, SCGD_A_MASK, MSK);
    acc(0, SCGD_A_MASK, {18'h0, MSK[45:0]});
    acc(1, SCGD_A_DBG, MSK);
    acc(0, SCGD_A_DBG, MSK);
    acc(0, SCGD_A_DBG + 1, 0);
  endtask
  // pin low about 3 clocks after the request, then 16 per unit plus 4
  task automatic gate(input logic e, input logic [23:0] dl, input logic r,
    input int lo, hi);
    acc(1, SCGD_A_DELAY, {40'h0, dl});
    acc(1, SCGD_A_GLB, {62'h0, e, 1'b0});
    acc(0, SCGD_A_GLB, {62'h0, e, 1'b0});
    rdy = r;
    sreq = 1;
    n = 0;
    while (!o_gating_active && n < hi) begin
      @(posedge i_clk_sys) #1 n++;
    end
    chk(n >= lo && n <= hi, 1);
    chk(o_clock_force_off, lo < hi ? MSK[45:0] : 0);
    sreq = 0;
    rdy = 0;
    repeat (8) @(posedge i_clk_sys);
    #1 chk(o_clock_force_off, 0);
  endtask
  // readiness held high must not shorten the delay
  task automatic t_delay;
    gate(1, 5, 1, 85, 89);
  endtask
  // release mid-count, then a full count again
  task automatic t_abort;
    sreq = 1;
    repeat (60) @(posedge i_clk_sys);
    #1 chk(o_gating_active, 0);
    sreq = 0;
    repeat (8) @(posedge i_clk_sys);
    #1 chk(o_gating_active, 0);
    gate(1, 5, 0, 85, 89);
  endtask
  task automatic t_ack;
    gate(0, 0, 1, 5, 9);
    gate(0, 0, 0, 200, 200);
    gate(0, 2, 0, 37, 41);
  endtask
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk_sys);
    #1 i_rst_n = 1;
    t_regs;
    t_delay;
    t_abort;
    t_ack;
    test_done;
  end
endmodule // sleep_clock_gating_delay_tb
bind scgd_gate_ctrl scgd_props props (.*);

// >>> verilog/scgd_gate_ctrl.sv
// scgd_gate_ctrl: sleep clock mask, gating delay and mode select
// assumes suspend acknowledge arrives from a pin; unit ready is same clock
`timescale 1ns/1ns

// Operation
// - with delay gating on, wait the 24-bit delay after ack, then gate
// - with delay gating on, the acknowledge-based readiness is ignored
// - delay gating off and delay non-zero: delay is timeout for ack gating
// - delay counts units of sixteen system clocks
// - delay register bits 63:24 read zero
// - set mask bits force matching clocks off on sleep entry
// - global bit 1 selects delay gating, zero selects ack gating
module scgd_gate_ctrl
  import scgd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire scgd_req_t i_msr_req,
  input wire logic i_suspend_acknowledge_n,
  input wire logic i_ack_based_gating,
  output scgd_rsp_t o_msr_rsp,
  output logic [SCGD_MASK_W-1:0] o_clock_force_off,
  output logic o_gating_active,
  output logic o_delay_gating_enable
);
  logic [SCGD_DELAY_W-1:0] gating_delay;
  logic [SCGD_MASK_W-1:0] sleep_clock_mask;
  logic delay_gating_enable;
  logic [SCGD_DATA_W-1:0] debug_output;
  logic susp_meta;
  logic susp_sync_n;
  logic susp_prev;
  scgd_state_t state;
  scgd_state_t next_state;
  logic [SCGD_DELAY_W-1:0] units;
  logic tick;
  logic [SCGD_MASK_W-1:0] next_force_off;
  scgd_rsp_t next_rsp;

  // address decode
  wire sel_delay = (i_msr_req.addr == SCGD_A_DELAY);
  wire sel_mask = (i_msr_req.addr == SCGD_A_MASK);
  wire sel_glb = (i_msr_req.addr == SCGD_A_GLB);
  wire sel_dbg = (i_msr_req.addr == SCGD_A_DBG);
  wire wr_delay = i_msr_req.wr && sel_delay;
  wire wr_mask = i_msr_req.wr && sel_mask;
  wire wr_glb = i_msr_req.wr && sel_glb;
  wire wr_dbg = i_msr_req.wr && sel_dbg;

  // pin synchroniser, first stage read only by the second
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      susp_meta <= 1'b1;
      susp_sync_n <= 1'b1;
      susp_prev <= 1'b0;
    end else begin
      susp_meta <= i_suspend_acknowledge_n;
      susp_sync_n <= susp_meta;
      susp_prev <= !susp_sync_n;
    end
  end

  wire susp_active = !susp_sync_n;
  wire susp_rise = susp_active && !susp_prev;

  // register writes; unused fields are dropped on purpose
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      gating_delay <= SCGD_DELAY_RST;
      sleep_clock_mask <= SCGD_MASK_RST;
      delay_gating_enable <= SCGD_EN_RST;
      debug_output <= SCGD_DBG_RST;
    end else begin
      if (wr_delay) gating_delay <= i_msr_req.wdata[SCGD_DELAY_W-1:0];
      if (wr_mask) sleep_clock_mask <= i_msr_req.wdata[SCGD_MASK_W-1:0];
      // bit 0 is not stored, so a stray one has no effect
      if (wr_glb) delay_gating_enable <= i_msr_req.wdata[SCGD_GLB_EN_BIT];
      if (wr_dbg) debug_output <= i_msr_req.wdata;
    end
  end

  scgd_tick_div #(
    .DIV(SCGD_TICK_DIV)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_restart(susp_rise),
    .o_tick(tick)
  );

  // elapsed units since acknowledge, saturating at the field limit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || susp_rise || !susp_active) begin
      units <= '0;
    end else if (tick && units != '1) begin
      units <= units + 1'b1;
    end
  end

  wire delay_done = (units >= gating_delay);
  wire timeout_on = (gating_delay != '0);
  // delay path, readiness ignored while delay mode is on
  // readiness or non-zero timeout in ack mode
  wire gate_now = delay_gating_enable ? delay_done :
                  (i_ack_based_gating || (timeout_on && delay_done));

  // sequencer: wait after ack, then hold clocks gated
  always_comb begin
    next_state = state;
    case (state)
      SCGD_IDLE: begin
        if (susp_rise) next_state = SCGD_WAIT;
      end
      SCGD_WAIT: begin
        if (!susp_active) next_state = SCGD_IDLE;
        else if (gate_now) next_state = SCGD_GATED;
      end
      SCGD_GATED: begin
        if (!susp_active) next_state = SCGD_IDLE;
      end
      default: next_state = SCGD_IDLE;
    endcase
  end

  // masked clocks forced off while gated
  assign next_force_off = (next_state == SCGD_GATED) ? sleep_clock_mask :
                          '0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= SCGD_IDLE;
      o_clock_force_off <= '0;
    end else begin
      state <= next_state;
      o_clock_force_off <= next_force_off;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_rsp.valid = i_msr_req.rd;
    next_rsp.rdata = '0;
    if (sel_delay) begin
      next_rsp.rdata = {40'h00_0000_0000, gating_delay};
    end else if (sel_mask) begin
      next_rsp.rdata = {18'h0_0000, sleep_clock_mask};
    end else if (sel_glb) begin
      next_rsp.rdata = {62'h0, delay_gating_enable, 1'b0};
    end else if (sel_dbg) begin
      next_rsp.rdata = debug_output;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_msr_rsp <= '0;
    end else begin
      o_msr_rsp.valid <= next_rsp.valid;
      if (i_msr_req.rd) o_msr_rsp.rdata <= next_rsp.rdata;
    end
  end

  assign o_gating_active = (state == SCGD_GATED);
  assign o_delay_gating_enable = delay_gating_enable;
endmodule // scgd_gate_ctrl

// >>> verilog/scgd_pkg.sv
// scgd_pkg: register map, field layout and timing for sleep clock gating
// assumes one system clock; model-specific register port is 64 bits wide
package scgd_pkg;
  localparam int unsigned SCGD_ADDR_W = 32;
  localparam int unsigned SCGD_DATA_W = 64;
  // register addresses as printed
  localparam logic [31:0] SCGD_A_DELAY = 32'h51700008;
  localparam logic [31:0] SCGD_A_MASK = 32'h51700009;
  localparam logic [31:0] SCGD_A_GLB = 32'h5170000b;
  localparam logic [31:0] SCGD_A_DBG = 32'h5170000c;
  // field layout
  localparam int unsigned SCGD_DELAY_W = 24;
  localparam int unsigned SCGD_MASK_W = 46;
  localparam int unsigned SCGD_GLB_EN_BIT = 1;
  // reset values
  localparam logic [23:0] SCGD_DELAY_RST = 24'h000000;
  localparam logic [45:0] SCGD_MASK_RST = 46'h0000_0000_0000;
  localparam logic SCGD_EN_RST = 1'b0;
  localparam logic [63:0] SCGD_DBG_RST = 64'h0000_0000_0000_0000;
  // one delay unit is this many system clocks
  localparam int unsigned SCGD_TICK_DIV = 16;

  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic rd;
    logic [63:0] wdata;
  } scgd_req_t;

  typedef struct packed {
    logic valid;
    logic [63:0] rdata;
  } scgd_rsp_t;

  typedef enum logic [1:0] {
    SCGD_IDLE,
    SCGD_WAIT,
    SCGD_GATED
  } scgd_state_t;
endpackage

// >>> verilog/scgd_tick_div.sv
// scgd_tick_div: one-cycle enable every DIV clocks
// assumes a synchronous active-low reset and a restart from the owner
`timescale 1ns/1ns
module scgd_tick_div #(
  parameter int unsigned DIV = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_restart,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;
  wire at_last = (cnt == LAST);

  // free counter, restart lines the first tick up with the event
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_restart || at_last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign o_tick = at_last && !i_restart;
endmodule // scgd_tick_div
